// File: common/pin_assoc_pkg.sv
// constants, register map and carrier types for the enable-pin association block
// assumes a single 125 MHz clock and an AXI4-Lite master with 32-bit data
// Contract
// - ext converter: pin high uses operating voltage
// - ext converter: pin low uses sleep voltage
// - ext converter pin low keep-on: low power
// - core2 follows pin: operating or sleep voltage
// - core2 pin low keep-on: low power
// - core1 follows pin: operating or sleep voltage
// - core1 pin low keep-on: low power
// - io converter on/off follows pin, keep-on qualified
// - io converter on while pin high
// - io converter pin low: off, or low power
// - association clear: pin ignored, registers govern
package pin_assoc_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] ASSOC_OFFSET     = 8'h00;
  localparam logic [7:0] OP_VOLT_OFFSET   = 8'h04;
  localparam logic [7:0] SLEEP_VOLT_OFFSET = 8'h08;
  localparam logic [7:0] DEFAULT_OFFSET   = 8'h0c;
  localparam logic [7:0] KEEP_ON_OFFSET   = 8'h10;
  localparam logic [7:0] STATUS_OFFSET    = 8'h14;

  // ==========================================================
  // field positions and reset values
  localparam int IO_BIT    = 0;
  localparam int CORE1_BIT = 1;
  localparam int CORE2_BIT = 2;
  localparam int EXT_BIT   = 3;
  localparam int SPARE_BIT = 4;
  localparam logic [4:0] ASSOC_RESET = 5'h00;
  localparam logic [7:0] VOLT_RESET  = 8'h00;
  localparam logic [3:0] KEEP_RESET  = 4'h0;
  localparam logic [7:0] VOLT_OFF    = 8'h00;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [7:0] volt;
    logic       on;
    logic       low_power;
  } supply_cmd_t;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'h1,
    BUS_WRESP = 3'h2,
    BUS_RRESP = 3'h4
  } bus_state_t;

endpackage : pin_assoc_pkg

// File: rtl/pin_assoc.sv
// enable-pin association register and per-regulator supply selection
// assumes RST_N is the turn-off reset and the pin is synchronous to REF_CLK
`timescale 1ns/10ps
module pin_assoc (
  input  wire logic                       REF_CLK,
  input  wire logic                       RST_N,
  input  wire logic                       SECOND_ENABLE_PIN,
  input  wire logic [31:0]                AWADDR,
  input  wire logic                       AWVALID,
  output      logic                       AWREADY,
  input  wire logic [31:0]                WDATA,
  input  wire logic [3:0]                 WSTRB,
  input  wire logic                       WVALID,
  output      logic                       WREADY,
  output      logic [1:0]                 BRESP,
  output      logic                       BVALID,
  input  wire logic                       BREADY,
  input  wire logic [31:0]                ARADDR,
  input  wire logic                       ARVALID,
  output      logic                       ARREADY,
  output      logic [31:0]                RDATA,
  output      logic [1:0]                 RRESP,
  output      logic                       RVALID,
  input  wire logic                       RREADY,
  output      pin_assoc_pkg::supply_cmd_t IO_CMD,
  output      pin_assoc_pkg::supply_cmd_t CORE1_CMD,
  output      pin_assoc_pkg::supply_cmd_t CORE2_CMD,
  output      pin_assoc_pkg::supply_cmd_t EXT_CMD
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [4:0]               assoc;
    logic [31:0]              op_volt;
    logic [31:0]              sleep_volt;
    logic [3:0]               dflt_on;
    logic [3:0]               keep_on;
    pin_assoc_pkg::bus_state_t wst;
    pin_assoc_pkg::bus_state_t rst;
    logic                     aw_got;
    logic                     w_got;
    logic [7:0]               awaddr;
    logic [31:0]              wdata;
    logic [3:0]               wstrb;
    logic [1:0]               bresp;
    logic [31:0]              rdata;
    logic [1:0]               rresp;
    logic [3:0]               cmd_on;
    logic [3:0]               cmd_lp;
    logic [31:0]              cmd_volt;
  } state_t;

  state_t st;
  state_t next_st;

  pin_assoc_pkg::supply_cmd_t sel [4];

  // ==========================================================
  // per-regulator selection
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_sel
      pin_assoc_pkg::supply_cmd_t reg_cmd;
      always_comb begin
        reg_cmd.volt      = st.op_volt[8*g +: 8];
        reg_cmd.on        = st.dflt_on[g];
        reg_cmd.low_power = 1'b0;
      end
      supply_select u_sel (
        .assoc       (st.assoc[g]),
        .pin         (SECOND_ENABLE_PIN),
        .keep_on     (st.keep_on[g]),
        .volt_scaled (g != pin_assoc_pkg::IO_BIT),
        .op_volt     (st.op_volt[8*g +: 8]),
        .sleep_volt  (st.sleep_volt[8*g +: 8]),
        .reg_cmd     (reg_cmd),
        .cmd         (sel[g])
      );
    end
  endgenerate

  // ==========================================================
  // register write helper
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  // ==========================================================
  // next state
  always_comb begin
    logic [31:0] m;
    m = 32'h0;
    next_st = st;
    for (int i = 0; i < 4; i++) begin
      next_st.cmd_on[i]         = sel[i].on;
      next_st.cmd_lp[i]         = sel[i].low_power;
      next_st.cmd_volt[8*i +: 8] = sel[i].volt;
    end
    // write channel
    case (st.wst)
      pin_assoc_pkg::BUS_IDLE: begin
        if (AWVALID && !st.aw_got) begin
          next_st.aw_got = 1'b1;
          next_st.awaddr = AWADDR[7:0];
        end
        if (WVALID && !st.w_got) begin
          next_st.w_got = 1'b1;
          next_st.wdata = WDATA;
          next_st.wstrb = WSTRB;
        end
        if (st.aw_got && st.w_got) begin
          next_st.aw_got = 1'b0;
          next_st.w_got  = 1'b0;
          next_st.bresp  = pin_assoc_pkg::RESP_OKAY;
          next_st.wst    = pin_assoc_pkg::BUS_WRESP;
          case (st.awaddr)
            pin_assoc_pkg::ASSOC_OFFSET: begin
              if (st.wstrb[0]) begin
                next_st.assoc = st.wdata[4:0];
              end
            end
            pin_assoc_pkg::OP_VOLT_OFFSET: begin
              next_st.op_volt = merge(st.op_volt, st.wdata, st.wstrb);
            end
            pin_assoc_pkg::SLEEP_VOLT_OFFSET: begin
              next_st.sleep_volt = merge(st.sleep_volt, st.wdata, st.wstrb);
            end
            pin_assoc_pkg::DEFAULT_OFFSET: begin
              if (st.wstrb[0]) begin
                next_st.dflt_on = st.wdata[3:0];
              end
            end
            pin_assoc_pkg::KEEP_ON_OFFSET: begin
              if (st.wstrb[0]) begin
                next_st.keep_on = st.wdata[3:0];
              end
            end
            pin_assoc_pkg::STATUS_OFFSET: ;
            default: next_st.bresp = pin_assoc_pkg::RESP_SLVERR;
          endcase
        end
      end
      pin_assoc_pkg::BUS_WRESP: begin
        if (BREADY) begin
          next_st.wst = pin_assoc_pkg::BUS_IDLE;
        end
      end
      default: next_st.wst = pin_assoc_pkg::BUS_IDLE;
    endcase
    // read channel
    case (st.rst)
      pin_assoc_pkg::BUS_IDLE: begin
        if (ARVALID) begin
          next_st.rst   = pin_assoc_pkg::BUS_RRESP;
          next_st.rresp = pin_assoc_pkg::RESP_OKAY;
          case (ARADDR[7:0])
            pin_assoc_pkg::ASSOC_OFFSET:      m = {27'h0, st.assoc};
            pin_assoc_pkg::OP_VOLT_OFFSET:    m = st.op_volt;
            pin_assoc_pkg::SLEEP_VOLT_OFFSET: m = st.sleep_volt;
            pin_assoc_pkg::DEFAULT_OFFSET:    m = {28'h0, st.dflt_on};
            pin_assoc_pkg::KEEP_ON_OFFSET:    m = {28'h0, st.keep_on};
            pin_assoc_pkg::STATUS_OFFSET:
              m = {23'h0, SECOND_ENABLE_PIN, st.cmd_lp, st.cmd_on};
            default: next_st.rresp = pin_assoc_pkg::RESP_SLVERR;
          endcase
          next_st.rdata = m;
        end
      end
      pin_assoc_pkg::BUS_RRESP: begin
        if (RREADY) begin
          next_st.rst = pin_assoc_pkg::BUS_IDLE;
        end
      end
      default: next_st.rst = pin_assoc_pkg::BUS_IDLE;
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st            <= '0;
      st.assoc      <= pin_assoc_pkg::ASSOC_RESET;
      st.op_volt    <= {4{pin_assoc_pkg::VOLT_RESET}};
      st.sleep_volt <= {4{pin_assoc_pkg::VOLT_RESET}};
      st.dflt_on    <= pin_assoc_pkg::KEEP_RESET;
      st.keep_on    <= pin_assoc_pkg::KEEP_RESET;
      st.wst        <= pin_assoc_pkg::BUS_IDLE;
      st.rst        <= pin_assoc_pkg::BUS_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs
  always_comb begin
    AWREADY = (st.wst == pin_assoc_pkg::BUS_IDLE) && !st.aw_got;
    WREADY  = (st.wst == pin_assoc_pkg::BUS_IDLE) && !st.w_got;
    BVALID  = (st.wst == pin_assoc_pkg::BUS_WRESP);
    BRESP   = st.bresp;
    ARREADY = (st.rst == pin_assoc_pkg::BUS_IDLE);
    RVALID  = (st.rst == pin_assoc_pkg::BUS_RRESP);
    RDATA   = st.rdata;
    RRESP   = st.rresp;
    IO_CMD    = '{volt: st.cmd_volt[7:0],   on: st.cmd_on[0], low_power: st.cmd_lp[0]};
    CORE1_CMD = '{volt: st.cmd_volt[15:8],  on: st.cmd_on[1], low_power: st.cmd_lp[1]};
    CORE2_CMD = '{volt: st.cmd_volt[23:16], on: st.cmd_on[2], low_power: st.cmd_lp[2]};
    EXT_CMD   = '{volt: st.cmd_volt[31:24], on: st.cmd_on[3], low_power: st.cmd_lp[3]};
  end

endmodule : pin_assoc

// File: rtl/supply_select.sv
// one regulator's selection between pin-driven and register-driven state
// assumes all inputs synchronous to the single clock
`timescale 1ns/10ps
module supply_select (
  input  wire logic                        assoc,
  input  wire logic                        pin,
  input  wire logic                        keep_on,
  input  wire logic                        volt_scaled,
  input  wire logic [7:0]                  op_volt,
  input  wire logic [7:0]                  sleep_volt,
  input  wire pin_assoc_pkg::supply_cmd_t  reg_cmd,
  output      pin_assoc_pkg::supply_cmd_t  cmd
);
  // ==========================================================
  // selection
  always_comb begin
    cmd = reg_cmd;
    if (assoc) begin
      if (volt_scaled) begin
        if (pin) begin
          cmd.volt      = op_volt;
          cmd.on        = (op_volt != pin_assoc_pkg::VOLT_OFF);
          cmd.low_power = 1'b0;
        end else begin
          cmd.volt      = sleep_volt;
          cmd.on        = (sleep_volt != pin_assoc_pkg::VOLT_OFF);
          cmd.low_power = keep_on &&
                          (sleep_volt != pin_assoc_pkg::VOLT_OFF);
        end
      end else begin
        cmd.volt      = reg_cmd.volt;
        cmd.on        = pin || keep_on;
        cmd.low_power = !pin && keep_on;
      end
    end
  end
endmodule : supply_select

// File: testbench/pin_assoc_properties.sv
// checker for the enable-pin association block, ports only
// assumes both write channels are offered together, as the bench does
`timescale 1ns/10ps
module pin_assoc_checker (
  input wire logic                       REF_CLK,
  input wire logic                       RST_N,
  input wire logic                       SECOND_ENABLE_PIN,
  input wire logic [31:0]                AWADDR,
  input wire logic                       AWVALID,
  input wire logic                       AWREADY,
  input wire logic [31:0]                WDATA,
  input wire logic                       WVALID,
  input wire logic                       WREADY,
  input wire pin_assoc_pkg::supply_cmd_t IO_CMD,
  input wire pin_assoc_pkg::supply_cmd_t CORE1_CMD,
  input wire pin_assoc_pkg::supply_cmd_t CORE2_CMD,
  input wire pin_assoc_pkg::supply_cmd_t EXT_CMD
);
  logic [3:0] sh;
  // ==========================================================
  // shadow of association bits
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) sh <= 4'h0;
    else if (AWVALID && AWREADY && WVALID && WREADY && AWADDR[7:0] == 8'h00) sh <= WDATA[3:0];
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  sequence io_hi; (sh[0] && SECOND_ENABLE_PIN) [*5]; endsequence
  sequence io_lo; (sh[0] && !SECOND_ENABLE_PIN) [*5]; endsequence
  sequence c1_hi; (sh[1] && SECOND_ENABLE_PIN) [*5]; endsequence
  // ==========================================================
  // properties
  a_io_pin_high: assert property (io_hi |-> IO_CMD.on && !IO_CMD.low_power)
    else $error("io off with pin high");
  a_io_pin_low: assert property (io_lo |-> IO_CMD.on == IO_CMD.low_power)
    else $error("io state wrong with pin low");
  a_core1_op_sel: assert property (c1_hi |-> !CORE1_CMD.low_power &&
    CORE1_CMD.on == (CORE1_CMD.volt != 8'h00)) else $error("core1 wrong with pin high");
  a_core1_low_pwr: assert property (CORE1_CMD.low_power |->
    CORE1_CMD.volt != 8'h00 && !$past(SECOND_ENABLE_PIN)) else $error("core1 low power");
  a_core2_low_pwr: assert property (CORE2_CMD.low_power |->
    CORE2_CMD.volt != 8'h00 && !$past(SECOND_ENABLE_PIN)) else $error("core2 low power");
  a_ext_low_pwr: assert property (EXT_CMD.low_power |->
    EXT_CMD.volt != 8'h00 && !$past(SECOND_ENABLE_PIN)) else $error("ext low power");
  a_ext_unlinked: assert property ((!sh[3]) [*5] |-> !EXT_CMD.low_power)
    else $error("ext low power while unlinked");
  a_reset_clear: assert property ($rose(RST_N) |-> {IO_CMD, CORE1_CMD} == 20'h0 &&
    {CORE2_CMD, EXT_CMD} == 20'h0) else $error("commands not cleared");
endmodule : pin_assoc_checker

bind pin_assoc pin_assoc_checker u_chk (.REF_CLK(REF_CLK), .RST_N(RST_N),
  .SECOND_ENABLE_PIN(SECOND_ENABLE_PIN), .AWADDR(AWADDR), .AWVALID(AWVALID),
  .AWREADY(AWREADY), .WDATA(WDATA), .WVALID(WVALID), .WREADY(WREADY), .IO_CMD(IO_CMD),
  .CORE1_CMD(CORE1_CMD), .CORE2_CMD(CORE2_CMD), .EXT_CMD(EXT_CMD));

// File: testbench/pin_driver.sv
// processor side driving the second enable pin
// assumes the requested level is set just after a clock edge
`timescale 1ns/10ps
module pin_driver (
  input  wire logic REF_CLK,
  input  wire logic want,
  output      logic pin = 1'h0
);
  // pin is a synchronous level, one edge after the request
  always_ff @(posedge REF_CLK) pin <= want;
endmodule : pin_driver

// File: testbench/tb_pin_assoc.sv
// self-checking bench for the enable-pin association block
// assumes pin_assoc_pkg, pin_driver and the bound checker are compiled
`timescale 1ns/10ps
module tb_pin_assoc;
  logic                       REF_CLK = 1'h0, RST_N = 1'h0, want = 1'h0, pin;
  logic                       AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0;
  logic                       ARVALID = 1'h0, RREADY = 1'h0;
  logic                       AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [1:0]                 BRESP, RRESP, rr, br;
  logic [31:0]                AWADDR = 32'h0, WDATA = 32'h0, ARADDR = 32'h0, RDATA, rd_d;
  logic [31:0]                op, sl, ko, as, pn, st_e;
  pin_assoc_pkg::supply_cmd_t cmd [4];
  pin_assoc_pkg::supply_cmd_t ex;
  int                         num_errors = 0, n_compared = 0, seed = 84, i, k;
  always #4 REF_CLK = ~REF_CLK;
  pin_driver u_pin (.REF_CLK(REF_CLK), .want(want), .pin(pin));
  pin_assoc dut (.REF_CLK(REF_CLK), .RST_N(RST_N), .SECOND_ENABLE_PIN(pin), .AWADDR(AWADDR),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(4'hf), .WVALID(WVALID),
    .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
    .RREADY(RREADY), .IO_CMD(cmd[0]), .CORE1_CMD(cmd[1]), .CORE2_CMD(cmd[2]), .EXT_CMD(cmd[3]));
  // ==========================================================
  // report and compare
  task summarize;
    $display("compared %0d, wrong %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  task cmp(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp
  task cmpc(input pin_assoc_pkg::supply_cmd_t g, input pin_assoc_pkg::supply_cmd_t e);
    cmp({22'h0, g}, {22'h0, e});
  endtask : cmpc
  // ==========================================================
  // bus tasks
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge REF_CLK);
    AWADDR <= {24'h0, a};
    WDATA <= d;
    AWVALID <= 1'h1;
    WVALID <= 1'h1;
    BREADY <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge REF_CLK);
      if (AWREADY) AWVALID <= 1'h0;
      if (WREADY) WVALID <= 1'h0;
      if (BVALID) begin
        br = BRESP;
        break;
      end
    end
    BREADY <= 1'h0;
    if (n == 50) begin
      num_errors++;
      summarize();
    end
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge REF_CLK);
    ARADDR <= {24'h0, a};
    ARVALID <= 1'h1;
    RREADY <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge REF_CLK);
      if (ARREADY) ARVALID <= 1'h0;
      d = RDATA;
      r = RRESP;
      if (RVALID) break;
    end
    RREADY <= 1'h0;
    if (n == 50) begin
      num_errors++;
      summarize();
    end
  endtask : rd
  // ==========================================================
  // expected command of one regulator
  function automatic pin_assoc_pkg::supply_cmd_t expc(input int k, input logic a, input logic p,
      input logic [7:0] o, input logic [7:0] s, input logic dflt, input logic kp);
    pin_assoc_pkg::supply_cmd_t c;
    c.volt = (a && k != 0 && !p) ? s : o;
    c.on = !a ? dflt : (k == 0) ? (p | kp) : (c.volt != 8'h00);
    c.low_power = a && !p && kp && (k == 0 || c.volt != 8'h00);
    return c;
  endfunction : expc
  initial begin
    repeat (5) @(posedge REF_CLK);
    RST_N <= 1'h1;
    rd(8'h00, rd_d, rr);
    cmp(rd_d, 32'h0);
    wr(8'h00, 32'hff);
    cmp({30'h0, br}, {30'h0, pin_assoc_pkg::RESP_OKAY});
    rd(8'h00, rd_d, rr);
    cmp(rd_d, 32'h1f);
    wr(8'h40, 32'h0);
    cmp({30'h0, br}, {30'h0, pin_assoc_pkg::RESP_SLVERR});
    rd(8'h40, rd_d, rr);
    cmp({30'h0, rr}, {30'h0, pin_assoc_pkg::RESP_SLVERR});
    $display("test registers done");
    for (i = 0; i < 48; i++) begin
      op = $random(seed) | 32'h1;
      sl = (i < 4) ? 32'h0 : $random(seed);
      if (i >= 4 && i < 8) op = op & 32'hff;
      ko = $random(seed);
      as = $random(seed);
      pn = $random(seed);
      wr(8'h04, op);
      wr(8'h08, sl);
      wr(8'h0c, {28'h0, ko[3:0]});
      wr(8'h10, {28'h0, ko[7:4]});
      wr(8'h00, {27'h0, as[4:0]});
      want <= pn[0];
      repeat (3) @(posedge REF_CLK);
      st_e = {23'h0, pn[0], 8'h00};
      for (k = 0; k < 4; k++) begin
        ex = expc(k, as[k], pn[0], op[8*k+:8], sl[8*k+:8], ko[k], ko[4+k]);
        cmpc(cmd[k], ex);
        st_e[k] = ex.on;
        st_e[4+k] = ex.low_power;
      end
      rd(8'h14, rd_d, rr);
      cmp(rd_d, st_e);
    end
    $display("test selection done");
    RST_N <= 1'h0;
    @(posedge REF_CLK);
    for (k = 0; k < 4; k++) cmpc(cmd[k], 10'h000);
    RST_N <= 1'h1;
    rd(8'h00, rd_d, rr);
    cmp(rd_d, 32'h0);
    $display("test reset done");
    summarize();
  end
endmodule : tb_pin_assoc
